//--- prs_flyback_model.sv
// supply capacitor, oscillator and current ramp of the primary side
// assumes one supply step per mclk; levels in tenths of a volt
module prs_flyback_model (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       chargeEnable,
	input  wire logic       hvRegEnable,
	input  wire logic       gateOn,
	input  wire logic       biasOn,
	input  wire logic [7:0] tripAt,
	output logic            vccAboveStart,
	output logic            vccAboveStop,
	output logic            vccAboveReg,
	output logic            oscTurnOn,
	output logic            pwmCompTrip
);
	timeunit 1ns;
	timeprecision 1ns;
	int vcc;
	int osc;
	int onCnt;
	assign vccAboveStart = vcc >= 120;
	assign vccAboveStop  = vcc > 80;
	assign vccAboveReg   = vcc > 100;
	assign oscTurnOn     = osc < 5;
	assign pwmCompTrip   = gateOn && onCnt >= int'(tripAt);
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			vcc <= 0;
			osc <= 0;
		end else begin
			osc <= (osc == 49) ? 0 : osc + 1;
			// bias winding overrides the regulator, as a real aux winding would
			if (biasOn) vcc <= 150;
			else if (chargeEnable || (hvRegEnable && vcc < 101)) vcc <= vcc + 1;
			else if (vcc > 0) vcc <= vcc - 1;
		end
		onCnt <= gateOn ? onCnt + 1 : 0;
	end
endmodule : prs_flyback_model

//--- prs_sequencer.sv
// constants, startup supply control, turn-on blanking, fault shutdown and shared auto-restart timing
// assumes comparator flags arrive asynchronously; nrst is the undervoltage_lockout reset
//
// Summary of operation
// R1: startup_charge_current stays on until supply reaches the 12 V start threshold.
// R2: in steady running the high_voltage_supply_regulator holds supply near 10 V.
// R3: regulator is switched off while a bias winding holds supply above 10 V.
// R4: current comparator ignored for 250 ns blanking_interval after every switch turn-on.
// R5: all faults share one auto-restart sequence; none latches off permanently.
// R6: any fault stops switching at once and keeps the switch off.
// R7: during the 1.6 s restart timer the regulator holds supply, switching halted.
// R8: after the restart count the regulator is disabled so supply decays.
// R9: at the 8 V stop threshold protection clears and charging restarts.
// R10: at the 12 V start threshold switching resumes; cycle repeats while fault persists.
// R11: overload delay timer starts when feedback_voltage reaches 4.4 V.
// R12: overload only if feedback stays above 4.4 V for full 100 ms delay.
// R13: abnormal sense current while gate is on causes shutdown.
// R14: supply above 24.5 V triggers supply_overvoltage_fault and stops switching.
// R15: junction temperature above 140 C triggers thermal_shutdown_fault.
// R16: after thermal shutdown restart only once temperature has dropped by 60 C.
// R17: comparator inputs synchronised; blanking, overload and restart timers count mclk.

package prs_pkg;
	localparam int  CLK_PERIOD_NS     = 10;
	localparam int  BLANK_TIME_NS     = 250;
	localparam int  OVERLOAD_TIME_MS  = 100;
	localparam int  RESTART_TIME_MS   = 1600;
	localparam int  NS_PER_MS         = 1000000;
	// least time: round up, never below one cycle
	localparam int  BLANK_CYCLES_I    = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  BLANK_W           = 5;
	localparam logic [BLANK_W-1:0] BLANK_CYCLES = BLANK_W'(BLANK_CYCLES_I);
	localparam int  TIMER_W           = 28;
	localparam longint OVERLOAD_CYCLES_L = longint'(OVERLOAD_TIME_MS) * NS_PER_MS / CLK_PERIOD_NS;
	localparam longint RESTART_CYCLES_L  = longint'(RESTART_TIME_MS) * NS_PER_MS / CLK_PERIOD_NS;
	localparam logic [TIMER_W-1:0] OVERLOAD_CYCLES = TIMER_W'(OVERLOAD_CYCLES_L);
	localparam logic [TIMER_W-1:0] RESTART_CYCLES  = TIMER_W'(RESTART_CYCLES_L);
	localparam int  SYNC_W            = 10;
	// bit positions inside the synchronised comparator vector
	localparam int  IN_VCC_START  = 0;
	localparam int  IN_VCC_STOP   = 1;
	localparam int  IN_VCC_REG    = 2;
	localparam int  IN_FB_OVL     = 3;
	localparam int  IN_SENSE_ABN  = 4;
	localparam int  IN_VCC_OVP    = 5;
	localparam int  IN_TEMP_TRIP  = 6;
	localparam int  IN_TEMP_COOL  = 7;
	localparam int  IN_PWM_TRIP   = 8;
	localparam int  IN_OSC_ON     = 9;
	localparam logic [SYNC_W-1:0] SYNC_RESET = {SYNC_W{1'b0}};
	typedef enum logic [1:0] {
		ST_CHARGE,
		ST_RUN,
		ST_FAULT_HOLD,
		ST_DECAY
	} prs_state_e;
endpackage : prs_pkg

module prs_sequencer
	import prs_pkg::*;
#(
	parameter logic [prs_pkg::TIMER_W-1:0] OVERLOAD_COUNT = prs_pkg::OVERLOAD_CYCLES,
	parameter logic [prs_pkg::TIMER_W-1:0] RESTART_COUNT  = prs_pkg::RESTART_CYCLES
) (
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic vccAboveStart,
	input  wire logic vccAboveStop,
	input  wire logic vccAboveReg,
	input  wire logic feedbackOverload,
	input  wire logic senseAbnormal,
	input  wire logic vccOverVoltage,
	input  wire logic tempAboveTrip,
	input  wire logic tempCooled,
	input  wire logic pwmCompTrip,
	input  wire logic oscTurnOn,
	output logic      gateOn,
	output logic      switchEnable,
	output logic      hvRegEnable,
	output logic      chargeEnable,
	output logic      blankActive,
	output logic      faultActive,
	output logic      thermalLatched
);
	import prs_pkg::*;

	logic [SYNC_W-1:0]  rawIn;
	logic [SYNC_W-1:0]  syncIn;
	logic               oscOnPrev_reg;
	logic               oscOnPrev_next;
	prs_state_e         state_reg;
	prs_state_e         state_next;
	logic [TIMER_W-1:0] ovlCount_reg;
	logic [TIMER_W-1:0] ovlCount_next;
	logic [TIMER_W-1:0] rstCount_reg;
	logic [TIMER_W-1:0] rstCount_next;
	logic [BLANK_W-1:0] blankCount_reg;
	logic [BLANK_W-1:0] blankCount_next;
	logic               gateOn_reg;
	logic               gateOn_next;
	logic               switchEnable_reg;
	logic               switchEnable_next;
	logic               hvRegEnable_reg;
	logic               hvRegEnable_next;
	logic               chargeEnable_reg;
	logic               chargeEnable_next;
	logic               blankActive_reg;
	logic               blankActive_next;
	logic               faultActive_reg;
	logic               faultActive_next;
	logic               thermal_reg;
	logic               thermal_next;
	logic               turnOnEdge;
	logic               overloadDone;
	logic               aocpHit;
	logic               anyFault;

	// true on the final cycle of a count that runs up from zero
	function automatic logic at_last(
		input logic [TIMER_W-1:0] count,
		input logic [TIMER_W-1:0] limit
	);
		return count == limit - TIMER_W'(1);
	endfunction : at_last

	assign rawIn[IN_VCC_START] = vccAboveStart;
	assign rawIn[IN_VCC_STOP]  = vccAboveStop;
	assign rawIn[IN_VCC_REG]   = vccAboveReg;
	assign rawIn[IN_FB_OVL]    = feedbackOverload;
	assign rawIn[IN_SENSE_ABN] = senseAbnormal;
	assign rawIn[IN_VCC_OVP]   = vccOverVoltage;
	assign rawIn[IN_TEMP_TRIP] = tempAboveTrip;
	assign rawIn[IN_TEMP_COOL] = tempCooled;
	assign rawIn[IN_PWM_TRIP]  = pwmCompTrip;
	assign rawIn[IN_OSC_ON]    = oscTurnOn;

	// analog flags and the oscillator pulse are foreign to mclk
	prs_sync #(
		.WIDTH   (SYNC_W)
	) u_sync (
		.mclk    (mclk),
		.nrst    (nrst),
		.asyncIn (rawIn),
		.syncOut (syncIn)
	); // [R17]

	always_comb begin
		oscOnPrev_next = syncIn[IN_OSC_ON];
		turnOnEdge     = syncIn[IN_OSC_ON] & ~oscOnPrev_reg;
		// counter stops one short of the limit and clears, so the fault fires exactly at the delay
		overloadDone   = syncIn[IN_FB_OVL] && at_last(ovlCount_reg, OVERLOAD_COUNT); // [R12]
		aocpHit        = gateOn_reg && syncIn[IN_SENSE_ABN]; // [R13]
		anyFault       = overloadDone                 // [R12]
		               || aocpHit                     // [R13]
		               || syncIn[IN_VCC_OVP]          // [R14]
		               || syncIn[IN_TEMP_TRIP]        // [R15]
		               || !syncIn[IN_VCC_STOP];       // [R5]
	end

	// overload delay timer runs only while feedback sits above the overload level
	always_comb begin
		ovlCount_next = '0;
		if (state_reg == ST_RUN && syncIn[IN_FB_OVL] && !overloadDone) begin
			ovlCount_next = ovlCount_reg + TIMER_W'(1); // [R11]
		end
	end // a short excursion restarts the count from zero [R12]

	always_comb begin
		state_next        = state_reg;
		rstCount_next     = rstCount_reg;
		thermal_next      = thermal_reg;
		chargeEnable_next = 1'b0;
		hvRegEnable_next  = 1'b0;
		switchEnable_next = 1'b0;
		faultActive_next  = 1'b0;
		if (syncIn[IN_TEMP_TRIP]) begin
			thermal_next = 1'b1; // [R15]
		end else if (syncIn[IN_TEMP_COOL]) begin
			thermal_next = 1'b0; // [R16]
		end
		unique case (state_reg)
			ST_CHARGE: begin
				chargeEnable_next = 1'b1; // [R1]
				hvRegEnable_next  = 1'b1;
				if (syncIn[IN_VCC_START]) begin
					state_next        = ST_RUN; // [R10]
					chargeEnable_next = 1'b0;
					hvRegEnable_next  = ~syncIn[IN_VCC_REG];
					switchEnable_next = 1'b1;
				end
			end
			ST_RUN: begin
				// bias winding above regulation takes over the supply
				hvRegEnable_next  = ~syncIn[IN_VCC_REG]; // [R2] [R3]
				switchEnable_next = 1'b1;
				if (anyFault) begin
					state_next        = ST_FAULT_HOLD; // [R5]
					switchEnable_next = 1'b0;           // [R6]
					faultActive_next  = 1'b1;
					rstCount_next     = '0;
				end
			end
			ST_FAULT_HOLD: begin
				hvRegEnable_next = ~syncIn[IN_VCC_REG]; // [R7]
				faultActive_next = 1'b1;
				if (at_last(rstCount_reg, RESTART_COUNT)) begin
					rstCount_next = '0;
					// still hot: another restart period rather than a permanent latch
					if (!thermal_next) begin
						state_next       = ST_DECAY; // [R8] [R16]
						hvRegEnable_next = 1'b0;
					end
				end else begin
					rstCount_next = rstCount_reg + TIMER_W'(1); // [R7]
				end
			end
			ST_DECAY: begin
				faultActive_next = 1'b1; // [R8]
				if (!syncIn[IN_VCC_STOP]) begin
					state_next        = ST_CHARGE; // [R9]
					faultActive_next  = 1'b0;
					chargeEnable_next = 1'b1;
					hvRegEnable_next  = 1'b1;
				end
			end
		endcase
	end

	// gate and blanking: the gate drops at once when switching is withdrawn
	always_comb begin
		gateOn_next      = gateOn_reg;
		blankCount_next  = blankCount_reg;
		blankActive_next = 1'b0;
		if (!switchEnable_next) begin
			gateOn_next     = 1'b0; // [R6]
			blankCount_next = '0;
		end else if (turnOnEdge && !gateOn_reg) begin
			gateOn_next      = 1'b1;
			blankCount_next  = BLANK_CYCLES - BLANK_W'(1); // [R4]
			blankActive_next = 1'b1;
		end else if (blankCount_reg != '0) begin
			blankCount_next  = blankCount_reg - BLANK_W'(1); // [R4]
			blankActive_next = 1'b1;
		end else if (gateOn_reg && syncIn[IN_PWM_TRIP]) begin
			gateOn_next = 1'b0; // comparator heard only once blanking is over [R4]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			oscOnPrev_reg <= 1'b0;
		end else begin
			oscOnPrev_reg <= oscOnPrev_next;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ovlCount_reg <= '0;
		end else begin
			ovlCount_reg <= ovlCount_next;
		end
	end

	// reset leaves the charge source and regulator on, as undervoltage lockout demands
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg        <= ST_CHARGE;
			rstCount_reg     <= '0;
			switchEnable_reg <= 1'b0;
			hvRegEnable_reg  <= 1'b1;
			chargeEnable_reg <= 1'b1;
			faultActive_reg  <= 1'b0;
			thermal_reg      <= 1'b0;
		end else begin
			state_reg        <= state_next;
			rstCount_reg     <= rstCount_next;
			switchEnable_reg <= switchEnable_next;
			hvRegEnable_reg  <= hvRegEnable_next;
			chargeEnable_reg <= chargeEnable_next;
			faultActive_reg  <= faultActive_next;
			thermal_reg      <= thermal_next;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			blankCount_reg  <= '0;
			gateOn_reg      <= 1'b0;
			blankActive_reg <= 1'b0;
		end else begin
			blankCount_reg  <= blankCount_next;
			gateOn_reg      <= gateOn_next;
			blankActive_reg <= blankActive_next;
		end
	end

	assign gateOn         = gateOn_reg;
	assign switchEnable   = switchEnable_reg;
	assign hvRegEnable    = hvRegEnable_reg;
	assign chargeEnable   = chargeEnable_reg;
	assign blankActive    = blankActive_reg;
	assign faultActive    = faultActive_reg;
	assign thermalLatched = thermal_reg;
endmodule : prs_sequencer

//--- prs_sequencer_assertions.sv
// port checker for prs_sequencer, bound onto the design
// assumes the 2-flop input sync, so an input acts 3 samples late
module prs_seq_chk
	import prs_pkg::*;
#(
	parameter logic [prs_pkg::TIMER_W-1:0] OVERLOAD_COUNT = prs_pkg::OVERLOAD_CYCLES,
	parameter logic [prs_pkg::TIMER_W-1:0] RESTART_COUNT  = prs_pkg::RESTART_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic vccAboveStart,
	input wire logic vccAboveReg,
	input wire logic vccOverVoltage,
	input wire logic tempAboveTrip,
	input wire logic gateOn,
	input wire logic switchEnable,
	input wire logic hvRegEnable,
	input wire logic chargeEnable,
	input wire logic blankActive,
	input wire logic faultActive,
	input wire logic thermalLatched
);
	logic [31:0] faultCyc_reg;
	logic [31:0] faultCyc_next;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	always_comb faultCyc_next = faultActive ? faultCyc_reg + 32'h1 : 32'h0;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) faultCyc_reg <= 32'h0;
		else faultCyc_reg <= faultCyc_next;
	end
	AST_GATE_OFF: assert property (!switchEnable |-> !gateOn)
		else $error("gate on with switching disabled");
	AST_BLANK: assert property (blankActive |-> gateOn)
		else $error("gate cut during blanking");
	AST_FAULT_STOP: assert property ($rose(faultActive) |-> !switchEnable && !gateOn)
		else $error("switching on fault entry");
	AST_HOLD_LEN: assert property ($fell(faultActive) |-> faultCyc_reg >= 32'(RESTART_COUNT))
		else $error("restart hold too short");
	AST_RECHARGE: assert property ($fell(faultActive) |-> chargeEnable && hvRegEnable)
		else $error("charging not resumed");
	AST_CHARGE_END: assert property ($fell(chargeEnable) |-> switchEnable && $past(vccAboveStart, 3))
		else $error("charge ended early");
	AST_REG: assert property (switchEnable && $past(switchEnable) |-> hvRegEnable == !$past(vccAboveReg, 3))
		else $error("regulator level wrong");
	AST_OVP: assert property (switchEnable && $past(vccOverVoltage, 2) |=> !switchEnable)
		else $error("overvoltage ignored");
	AST_THERMAL: assert property (switchEnable && $past(tempAboveTrip, 2) |=> faultActive && thermalLatched)
		else $error("thermal trip ignored");
	AST_THERMAL_HOLD: assert property (thermalLatched && faultActive |=> faultActive)
		else $error("restart while hot");
	cover property ($fell(faultActive));
	cover property ($rose(thermalLatched));
	cover property ($fell(gateOn) && switchEnable);
endmodule : prs_seq_chk

bind prs_sequencer prs_seq_chk #(
	.OVERLOAD_COUNT (OVERLOAD_COUNT),
	.RESTART_COUNT  (RESTART_COUNT)
) chk (
	.mclk           (mclk),
	.nrst           (nrst),
	.vccAboveStart  (vccAboveStart),
	.vccAboveReg    (vccAboveReg),
	.vccOverVoltage (vccOverVoltage),
	.tempAboveTrip  (tempAboveTrip),
	.gateOn         (gateOn),
	.switchEnable   (switchEnable),
	.hvRegEnable    (hvRegEnable),
	.chargeEnable   (chargeEnable),
	.blankActive    (blankActive),
	.faultActive    (faultActive),
	.thermalLatched (thermalLatched)
);

//--- prs_sequencer_tb.sv
// self-checking bench for prs_sequencer beside the flyback model
// assumes short counts: overload 20 and restart 40 cycles
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
	$display("unexpected %s: expected %0h seen %0h", n, e, a); end end
module prs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, nrst = 0, biasOn = 0, fbOvl = 0, sense = 0, supply_overvoltage_fault = 0, hot = 0, cool = 0;
	logic [7:0] tripAt = 8'h02;
	logic vStart, vStop, vReg, osc, pwm, gateOn, swEn, hvReg, chg, blank, fault, therm;
	int mismatches = 0, check_count = 0, w;
	wire [3:0] obs = {fault, swEn, gateOn, hvReg};
	prs_sequencer #(.OVERLOAD_COUNT(28'h14), .RESTART_COUNT(28'h28)) dut (.mclk(mclk), .nrst(nrst),
		.vccAboveStart(vStart), .vccAboveStop(vStop), .vccAboveReg(vReg), .feedbackOverload(fbOvl),
		.senseAbnormal(sense), .vccOverVoltage(supply_overvoltage_fault), .tempAboveTrip(hot), .tempCooled(cool),
		.pwmCompTrip(pwm), .oscTurnOn(osc), .gateOn(gateOn), .switchEnable(swEn), .hvRegEnable(hvReg),
		.chargeEnable(chg), .blankActive(blank), .faultActive(fault), .thermalLatched(therm));
	prs_flyback_model plant (.mclk(mclk), .nrst(nrst), .chargeEnable(chg), .hvRegEnable(hvReg),
		.gateOn(gateOn), .biasOn(biasOn), .tripAt(tripAt), .vccAboveStart(vStart),
		.vccAboveStop(vStop), .vccAboveReg(vReg), .oscTurnOn(osc), .pwmCompTrip(pwm));
	initial forever #5 mclk = ~mclk;
	task automatic print_verdict;
		if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// bounded wait on one observed output, n returns cycles spent
	task automatic waitv(input int b, input logic v, input int lim, output int n);
		n = 0;
		while (obs[b] !== v && n < lim) begin
			@(negedge mclk);
			n++;
		end
		`CHK("waited level", v, obs[b])
	endtask : waitv
	task automatic t_blank(input logic [7:0] t, input int lo, input int hi);
		tripAt = t;
		waitv(1, 1'b0, 100, w);
		waitv(1, 1'b1, 100, w);
		// blanking covers 25 cycles from the turn-on edge, the gate is still on at its last one
		repeat (24) @(negedge mclk);
		`CHK("blank held", 1'b1, blank)
		@(negedge mclk);
		`CHK("blank end", 1'b0, blank)
		waitv(1, 1'b0, 100, w);
		`CHK("gate width", 1'b1, w + 25 >= lo && w + 25 <= hi)
	endtask : t_blank
	task automatic t_bias;
		biasOn = 1;
		repeat (10) @(negedge mclk);
		`CHK("reg with bias", 1'b0, hvReg)
		biasOn = 0;
		waitv(0, 1'b1, 100, w);
	endtask : t_bias
	task automatic t_olp_short;
		fbOvl = 1;
		repeat (10) @(negedge mclk);
		fbOvl = 0;
		repeat (40) @(negedge mclk);
		`CHK("short overload", 1'b0, fault)
	endtask : t_olp_short
	task automatic t_fault(input int k);
		int lo[4] = '{0, 0, 20, 0};
		int hi[4] = '{4, 55, 26, 4};
		int held = 0;
		waitv(2, 1'b1, 300, w);
		case (k)
			0: supply_overvoltage_fault = 1;
			1: sense = 1;
			2: fbOvl = 1;
			default: hot = 1;
		endcase
		waitv(3, 1'b1, 60, w);
		`CHK("fault delay", 1'b1, w >= lo[k] && w <= hi[k])
		`CHK("switch off", 1'b0, swEn)
		{supply_overvoltage_fault, sense, fbOvl, hot} = 4'h0;
		if (k == 3) begin
			`CHK("thermal flag", 1'b1, therm)
			repeat (150) @(negedge mclk);
			held = 150;
			`CHK("hot hold", 1'b1, fault)
			cool = 1;
		end
		waitv(3, 1'b0, 300, w);
		`CHK("hold length", 1'b1, w + held >= 40)
		`CHK("recharge", 1'b1, chg)
		cool = 0;
	endtask : t_fault
	initial begin
		repeat (5) @(negedge mclk);
		`CHK("reset charge", 1'b1, chg)
		nrst = 1;
		waitv(2, 1'b1, 300, w);
		`CHK("charge after start", 1'b0, chg)
		t_blank(8'h02, 25, 27);
		t_blank(8'h28, 40, 46);
		t_bias();
		t_olp_short();
		for (int k = 0; k < 4; k++) t_fault(k);
		print_verdict();
	end
	// whole run is about 1000 cycles
	initial begin
		#100us;
		mismatches++;
		print_verdict();
	end
endmodule : prs_sequencer_tb

//--- prs_sync.sv
// two-flop synchroniser for the asynchronous comparator flags of the sequencer
// assumes one 100 MHz oscillator clock and an asynchronous active-low reset

module prs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage1_next;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage2_next;

	always_comb begin
		stage1_next = asyncIn;
		stage2_next = stage1_reg;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
		end
	end

	assign syncOut = stage2_reg;
endmodule : prs_sync
